/* air_pkg.sv */
// Package: register map, field positions, reset values and modes of the result/interrupt block
package air_pkg;
    // Register offsets (byte addresses on the peripheral port)
    localparam logic [7:0] AIR_OFS_IRQ_ENABLE = 8'h0a;
    localparam logic [7:0] AIR_OFS_IRQ_FLAGS = 8'h0b;
    localparam logic [7:0] AIR_OFS_DEBUG_CONTROL = 8'h0c;
    localparam logic [7:0] AIR_OFS_BYTE_STAGING = 8'h0d;
    localparam logic [7:0] AIR_OFS_RESULT_LOW = 8'h10;
    localparam logic [7:0] AIR_OFS_RESULT_HIGH = 8'h11;
    // Block-local configuration registers (window mode and thresholds)
    localparam logic [7:0] AIR_OFS_WINDOW_SELECT = 8'h04;
    localparam logic [7:0] AIR_OFS_WIN_LOW_L = 8'h12;
    localparam logic [7:0] AIR_OFS_WIN_LOW_H = 8'h13;
    localparam logic [7:0] AIR_OFS_WIN_HIGH_L = 8'h14;
    localparam logic [7:0] AIR_OFS_WIN_HIGH_H = 8'h15;
    // Field positions
    localparam int AIR_BIT_RESULT_READY = 0;
    localparam int AIR_BIT_WINDOW_MATCH = 1;
    localparam int AIR_BIT_RUN_IN_DEBUG = 0;
    // Reset values
    localparam logic [7:0] AIR_RST_BYTE = 8'h00;
    localparam logic [15:0] AIR_RST_WORD = 16'h0000;
    // Converter code limits
    localparam logic [9:0] AIR_CODE_MAX = 10'h3ff;
    localparam logic [9:0] AIR_CODE_MIN = 10'h000;
    localparam logic [15:0] AIR_ACC_CEILING = 16'hffc0;
    localparam int AIR_ACC_MAX_COUNT = 64;
    // Window compare modes
    typedef enum logic [2:0] {
        AIR_WIN_NONE = 3'h0,
        AIR_WIN_BELOW = 3'h1,
        AIR_WIN_ABOVE = 3'h2,
        AIR_WIN_INSIDE = 3'h3,
        AIR_WIN_OUTSIDE = 3'h4
    } air_win_mode_e;
endpackage : air_pkg

/* air_window_cmp.sv */
// Window comparator: decides a match of a finished result against the thresholds
`timescale 1ns/1ps
module air_window_cmp
    import air_pkg::*;
(
    input wire logic [2:0] mode, // Window compare select
    input wire logic [15:0] value, // Final (accumulated) result
    input wire logic [15:0] low_thr, // Low threshold
    input wire logic [15:0] high_thr, // High threshold
    output logic match // Value satisfies the mode
);
    // Mode decode, reserved codes never match
    always_comb begin
        case (mode)
            AIR_WIN_BELOW: match = (value < low_thr);
            AIR_WIN_ABOVE: match = (value > high_thr);
            AIR_WIN_INSIDE: match = (value > low_thr) && (value < high_thr);
            AIR_WIN_OUTSIDE: match = (value < low_thr) || (value > high_thr);
            default: match = 1'b0;
        endcase
    end
endmodule : air_window_cmp

/* air_result_irq.sv */
// Result, interrupt flag, debug-run and byte-staging logic of the converter
//
// Notes on behaviour
// - Window interrupt only when enable bit1 set
// - Ready interrupt only when enable bit0 set
// - Window flag set on matching finished result
// - Ready flag set on every finished result
// - Writing one clears flag, zero keeps it
// - Reading result clears both flags
// - Debug halt without run bit ignores events
// - Run bit set keeps converting during halt
// - One shared read/write byte staging register
// - Result low at base, high at base+1
// - Overrange sample saturates at 0x3ff
// - Underrange sample forced to zero
// - Accumulated result never exceeds 0xffc0
// - Window modes none/below/above/inside/outside
// - Window compares the final accumulated value
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module air_result_irq
    import air_pkg::*;
#(
    parameter int SAMPLE_W = 10, // Converter code width
    parameter int RESULT_W = 16 // Result/accumulator width
) (
    input wire logic clk, // 10 MHz peripheral clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, one cycle after strobe
    input wire logic debug_halt, // Processor stopped in break debug
    input wire logic [SAMPLE_W-1:0] sample_code, // Raw sample from the core
    input wire logic sample_over, // Input above reference
    input wire logic sample_under, // Input below zero volts
    input wire logic sample_valid, // One-cycle sample strobe
    input wire logic sample_last, // Sample ends the accumulation
    input wire logic start_event, // Incoming trigger event
    output logic start_req, // Event passed to the core
    output logic conv_run, // Core may run
    output logic result_ready_irq, // Ready request
    output logic window_match_irq, // Window request
    output logic irq // Combined level interrupt
);
    // Software-visible state
    logic [7:0] irq_enable_q; // Interrupt enables
    logic [1:0] irq_flags_q; // Sticky flags
    logic run_in_debug_halt_q; // Debug-run bit
    logic [7:0] byte_staging_q; // Shared staging byte
    logic [RESULT_W-1:0] conversion_result_q; // Published result
    logic [2:0] window_compare_select_q; // Window mode
    logic [15:0] window_low_threshold_q; // Low threshold
    logic [15:0] window_high_threshold_q; // High threshold
    // Accumulation path
    logic [RESULT_W-1:0] acc_q; // Running sum
    logic [RESULT_W-1:0] acc_d; // Sum including this sample
    logic [SAMPLE_W-1:0] clamped; // Saturated sample
    logic active; // Core allowed to operate
    logic done; // A result finishes this cycle
    logic match; // Finished result matches window
    logic rd_result; // Read of either result byte
    logic [7:0] rdata_d; // Next read data

    // Address match helper, used by every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    // Halt unless the debug-run bit keeps us going
    assign active = !debug_halt || run_in_debug_halt_q;
    assign conv_run = active;
    assign start_req = start_event && active;
    assign done = sample_valid && sample_last && active;
    assign rd_result = reg_rd && (hit(reg_addr, AIR_OFS_RESULT_LOW)
        || hit(reg_addr, AIR_OFS_RESULT_HIGH));

    // Saturation of out-of-range samples
    always_comb begin
        if (sample_over) begin
            clamped = AIR_CODE_MAX;
        end else if (sample_under) begin
            clamped = AIR_CODE_MIN;
        end else begin
            clamped = sample_code;
        end
    end

    // Sum with clamp at the ceiling
    always_comb begin
        logic [RESULT_W:0] sum;
        sum = {1'b0, acc_q} + {{(RESULT_W + 1 - SAMPLE_W){1'b0}}, clamped};
        if (sum > {1'b0, AIR_ACC_CEILING}) begin
            acc_d = AIR_ACC_CEILING;
        end else begin
            acc_d = sum[RESULT_W-1:0];
        end
    end

    // Running accumulator, restarts after each finished result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= AIR_RST_WORD;
        end else if (done) begin
            acc_q <= AIR_RST_WORD;
        end else if (sample_valid && active) begin
            acc_q <= acc_d;
        end
    end

    // Publish final value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_result_q <= AIR_RST_WORD;
        end else if (done) begin
            conversion_result_q <= acc_d;
        end
    end

    // Window check on the final accumulated value
    air_window_cmp u_cmp (
        .mode(window_compare_select_q),
        .value(acc_d),
        .low_thr(window_low_threshold_q),
        .high_thr(window_high_threshold_q),
        .match(match)
    );

    // Flags: set wins over write-one clear and result read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flags_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (done && (i == AIR_BIT_RESULT_READY || match)) begin
                    irq_flags_q[i] <= 1'b1;
                end else if (rd_result) begin
                    irq_flags_q[i] <= 1'b0;
                end else if (reg_wr && hit(reg_addr, AIR_OFS_IRQ_FLAGS) && reg_wdata[i]) begin
                    irq_flags_q[i] <= 1'b0;
                end
            end
        end
    end

    // Plain control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_q <= AIR_RST_BYTE;
            run_in_debug_halt_q <= 1'b0;
            window_compare_select_q <= 3'h0;
            window_low_threshold_q <= AIR_RST_WORD;
            window_high_threshold_q <= AIR_RST_WORD;
        end else if (reg_wr) begin
            if (hit(reg_addr, AIR_OFS_IRQ_ENABLE)) begin
                irq_enable_q <= {6'h00, reg_wdata[1:0]};
            end
            if (hit(reg_addr, AIR_OFS_DEBUG_CONTROL)) begin
                run_in_debug_halt_q <= reg_wdata[AIR_BIT_RUN_IN_DEBUG];
            end
            if (hit(reg_addr, AIR_OFS_WINDOW_SELECT)) begin
                window_compare_select_q <= reg_wdata[2:0];
            end
            // High byte writes commit the staged low byte atomically
            if (hit(reg_addr, AIR_OFS_WIN_LOW_H)) begin
                window_low_threshold_q <= {reg_wdata, byte_staging_q};
            end
            if (hit(reg_addr, AIR_OFS_WIN_HIGH_H)) begin
                window_high_threshold_q <= {reg_wdata, byte_staging_q};
            end
        end
    end

    // Shared staging byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_staging_q <= AIR_RST_BYTE;
        end else if (reg_rd && hit(reg_addr, AIR_OFS_RESULT_LOW)) begin
            byte_staging_q <= conversion_result_q[15:8];
        end else if (reg_wr && (hit(reg_addr, AIR_OFS_BYTE_STAGING)
            || hit(reg_addr, AIR_OFS_WIN_LOW_L) || hit(reg_addr, AIR_OFS_WIN_HIGH_L))) begin
            byte_staging_q <= reg_wdata;
        end
    end

    // Read mux, unmapped reads zero
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            AIR_OFS_IRQ_ENABLE: rdata_d = irq_enable_q;
            AIR_OFS_IRQ_FLAGS: rdata_d = {6'h00, irq_flags_q};
            AIR_OFS_DEBUG_CONTROL: rdata_d = {7'h00, run_in_debug_halt_q};
            AIR_OFS_BYTE_STAGING: rdata_d = byte_staging_q;
            AIR_OFS_RESULT_LOW: rdata_d = conversion_result_q[7:0];
            AIR_OFS_RESULT_HIGH: rdata_d = byte_staging_q;
            AIR_OFS_WINDOW_SELECT: rdata_d = {5'h00, window_compare_select_q};
            AIR_OFS_WIN_LOW_L: rdata_d = window_low_threshold_q[7:0];
            AIR_OFS_WIN_LOW_H: rdata_d = window_low_threshold_q[15:8];
            AIR_OFS_WIN_HIGH_L: rdata_d = window_high_threshold_q[7:0];
            AIR_OFS_WIN_HIGH_H: rdata_d = window_high_threshold_q[15:8];
            default: rdata_d = 8'h00;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Requests
    assign result_ready_irq = irq_flags_q[AIR_BIT_RESULT_READY]
        && irq_enable_q[AIR_BIT_RESULT_READY];
    assign window_match_irq = irq_flags_q[AIR_BIT_WINDOW_MATCH]
        && irq_enable_q[AIR_BIT_WINDOW_MATCH];
    assign irq = result_ready_irq || window_match_irq;

    // Checks
    AST_READY_SET: assert property (@(posedge clk) disable iff (!rst_n)
        done |=> irq_flags_q[AIR_BIT_RESULT_READY])
        else $error("ready flag not set after result");
    AST_WIN_SET: assert property (@(posedge clk) disable iff (!rst_n)
        done && match |=> irq_flags_q[AIR_BIT_WINDOW_MATCH])
        else $error("window flag not set on match");
    AST_W1C: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_IRQ_FLAGS && reg_wdata[0] && !done |=> !irq_flags_q[0])
        else $error("write one did not clear flag");
    AST_W0_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_IRQ_FLAGS && !reg_wdata[0] && irq_flags_q[0]
        |=> irq_flags_q[0])
        else $error("write zero changed flag");
    AST_RD_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        rd_result && !done |=> irq_flags_q == 2'h0)
        else $error("result read did not clear flags");
    AST_HALT: assert property (@(posedge clk) disable iff (!rst_n)
        debug_halt && !run_in_debug_halt_q |-> !start_req && !conv_run)
        else $error("events passed during debug halt");
    AST_RUN: assert property (@(posedge clk) disable iff (!rst_n)
        run_in_debug_halt_q |-> conv_run)
        else $error("halted with debug-run set");
    AST_CEIL: assert property (@(posedge clk) disable iff (!rst_n)
        conversion_result_q <= AIR_ACC_CEILING)
        else $error("result above ceiling");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(irq_flags_q & irq_enable_q[1:0]))
        else $error("irq differs from flag and enable");
    AST_STAGE: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == AIR_OFS_RESULT_LOW |=> byte_staging_q == $past(conversion_result_q[15:8]))
        else $error("high byte not staged");

    // Enables gate the requests and bits 1:0 are stored as written, upper bits read zero
    AST_WIN_EN_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_IRQ_ENABLE && !reg_wdata[AIR_BIT_WINDOW_MATCH]
        |=> !window_match_irq)
        else $error("window request without enable");
    AST_RDY_EN_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_IRQ_ENABLE && !reg_wdata[AIR_BIT_RESULT_READY]
        |=> !result_ready_irq)
        else $error("ready request without enable");
    AST_WIN_EN_ON: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_IRQ_ENABLE && reg_wdata[1] |=> irq_enable_q[1])
        else $error("window enable not stored");
    AST_RDY_EN_ON: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_IRQ_ENABLE && reg_wdata[0] |=> irq_enable_q[0])
        else $error("ready enable not stored");

    // Flags rise only with a finished result
    AST_RDY_ONLY_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        !done && !irq_flags_q[AIR_BIT_RESULT_READY] |=> !irq_flags_q[AIR_BIT_RESULT_READY])
        else $error("ready flag set without result");
    AST_WIN_ONLY_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
        !(done && match) && !irq_flags_q[AIR_BIT_WINDOW_MATCH]
        |=> !irq_flags_q[AIR_BIT_WINDOW_MATCH])
        else $error("window flag set without match");
    AST_NO_COMPARE: assert property (@(posedge clk) disable iff (!rst_n)
        window_compare_select_q == AIR_WIN_NONE || window_compare_select_q > AIR_WIN_OUTSIDE |-> !match)
        else $error("match with compare off or reserved");

    // Flags hold until a write of one or a result read
    AST_RDY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        irq_flags_q[0] && !rd_result
        && !(reg_wr && reg_addr == AIR_OFS_IRQ_FLAGS && reg_wdata[0]) |=> irq_flags_q[0])
        else $error("ready flag dropped by itself");
    AST_WIN_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        irq_flags_q[1] && !rd_result
        && !(reg_wr && reg_addr == AIR_OFS_IRQ_FLAGS && reg_wdata[1]) |=> irq_flags_q[1])
        else $error("window flag dropped by itself");

    // Write-one clear and write-zero keep of the window flag
    AST_W1C_WIN: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_IRQ_FLAGS && reg_wdata[1] && !done |=> !irq_flags_q[1])
        else $error("write one did not clear window flag");
    AST_W0_KEEP_WIN: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_IRQ_FLAGS && !reg_wdata[1] && irq_flags_q[1]
        |=> irq_flags_q[1])
        else $error("write zero changed window flag");

    // Result publication and saturation of single samples
    AST_RES_PUB: assert property (@(posedge clk) disable iff (!rst_n)
        done |=> conversion_result_q == $past(acc_d))
        else $error("finished result not published");
    AST_RES_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !done |=> $stable(conversion_result_q))
        else $error("result changed without a finished conversion");
    AST_SAT_HI: assert property (@(posedge clk) disable iff (!rst_n)
        done && sample_over && acc_q == AIR_RST_WORD |=> conversion_result_q == {6'h00, AIR_CODE_MAX})
        else $error("overrange sample not saturated");
    AST_SAT_LO: assert property (@(posedge clk) disable iff (!rst_n)
        done && sample_under && !sample_over && acc_q == AIR_RST_WORD
        |=> conversion_result_q == AIR_RST_WORD)
        else $error("underrange sample not zero");

    // Halt freezes the sum and keeps the ready flag from rising, debug-run keeps summing
    AST_HALT_ACC: assert property (@(posedge clk) disable iff (!rst_n)
        !active |=> $stable(acc_q))
        else $error("sample taken during debug halt");
    AST_HALT_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        !active && !irq_flags_q[0] |=> !irq_flags_q[0])
        else $error("result flagged during debug halt");
    AST_RUN_ACC: assert property (@(posedge clk) disable iff (!rst_n)
        debug_halt && run_in_debug_halt_q && sample_valid && !sample_last
        |=> acc_q == $past(acc_d))
        else $error("sample dropped with debug-run set");

    // Staging byte, threshold commit and result byte reads
    AST_STAGE_WR: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_BYTE_STAGING |=> byte_staging_q == $past(reg_wdata))
        else $error("staging write lost");
    AST_THR_COMMIT: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == AIR_OFS_WIN_LOW_H
        |=> window_low_threshold_q == {$past(reg_wdata), $past(byte_staging_q)})
        else $error("low threshold not committed with staged byte");
    AST_RD_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == AIR_OFS_RESULT_LOW && !done
        |=> reg_rdata == conversion_result_q[7:0])
        else $error("low result byte wrong");
    AST_RD_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == AIR_OFS_RESULT_HIGH |=> reg_rdata == $past(byte_staging_q))
        else $error("high result byte not from staging");

    CV_DONE: cover property (@(posedge clk) disable iff (!rst_n) done && match);
    CV_HALT: cover property (@(posedge clk) disable iff (!rst_n) debug_halt && start_event && !active);
    CV_ACC: cover property (@(posedge clk) disable iff (!rst_n) sample_valid && !sample_last ##1 done);
    CV_IRQ: cover property (@(posedge clk) disable iff (!rst_n) irq ##1 rd_result);
endmodule : air_result_irq

/* air_core_model.sv */
// Behavioural model of the conversion core that feeds samples to the result block
`timescale 1ns/1ps
module air_core_model
    import air_pkg::*;
(
    input wire logic clk, // Peripheral clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic start_req, // Trigger from the block
    input wire logic conv_run, // Core may run
    input wire logic [9:0] ain_code, // Code the analog input would give
    input wire logic ain_over, // Analog input above reference
    input wire logic ain_under, // Analog input below zero volts
    input wire logic [6:0] n_samples, // Samples per accumulation
    output logic [9:0] sample_code, // Raw sample
    output logic sample_over, // Over-range flag
    output logic sample_under, // Under-range flag
    output logic sample_valid, // One-cycle sample strobe
    output logic sample_last // Last sample of the accumulation
);
    logic busy; // Conversion in flight
    logic [1:0] dly; // Cycles before the first sample
    logic [6:0] left; // Samples still to deliver
    // Delivers samples after a trigger; between samples the lines toggle so stale data never match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {busy, dly, left, sample_code, sample_over, sample_under} <= '0;
            sample_valid <= 1'b0;
            sample_last <= 1'b0;
        end else begin
            sample_valid <= 1'b0;
            sample_code <= ~sample_code;
            sample_over <= ~sample_over;
            sample_under <= ~sample_under;
            sample_last <= ~sample_last;
            if (busy && conv_run) begin
                // Halted core delivers nothing while conv_run is low
                if (dly != 2'h0) begin
                    dly <= dly - 2'h1;
                end else begin
                    sample_valid <= 1'b1;
                    sample_code <= ain_code;
                    sample_over <= ain_over;
                    sample_under <= ain_under;
                    sample_last <= (left == 7'h01);
                    left <= left - 7'h01;
                    busy <= (left != 7'h01);
                end
            end else if (start_req && !busy) begin
                busy <= 1'b1;
                dly <= 2'h2;
                left <= n_samples;
            end
        end
    end
endmodule : air_core_model

/* tb_top.sv */
// Self-checking testbench of the result, flag and debug-run block
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    import air_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, debug_halt = 1'b0;
    logic start_event = 1'b0, ain_over = 1'b0, ain_under = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic [9:0] ain_code = 10'h000, sample_code;
    logic [6:0] n_samples = 7'h01;
    logic sample_over, sample_under, sample_valid, sample_last, start_req, conv_run;
    logic result_ready_irq, window_match_irq, irq;
    int errors = 0, cmp_count = 0, cyc = 0;
    logic [9:0] codes [3] = '{10'h050, 10'h200, 10'h3ff};
    air_result_irq uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_halt(debug_halt),
        .sample_code(sample_code), .sample_over(sample_over), .sample_under(sample_under),
        .sample_valid(sample_valid), .sample_last(sample_last), .start_event(start_event),
        .start_req(start_req), .conv_run(conv_run), .result_ready_irq(result_ready_irq),
        .window_match_irq(window_match_irq), .irq(irq));
    air_core_model core (.clk(clk), .rst_n(rst_n), .start_req(start_req), .conv_run(conv_run),
        .ain_code(ain_code), .ain_over(ain_over), .ain_under(ain_under), .n_samples(n_samples),
        .sample_code(sample_code), .sample_over(sample_over), .sample_under(sample_under),
        .sample_valid(sample_valid), .sample_last(sample_last));
    // 10 MHz clock
    initial begin
        forever #50 clk = ~clk;
    end
    // Prints the counts and the verdict, then ends the run
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // Cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // One-cycle register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // Read and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a, d);
        `CHK(d, e)
    endtask : rchk
    // Pulses the trigger and checks whether it reaches the core
    task automatic trig(input logic e);
        @(posedge clk);
        start_event <= 1'b1;
        #1 `CHK(start_req, e)
        @(posedge clk);
        start_event <= 1'b0;
    endtask : trig
    // Runs one conversion through the core model and waits for the result
    task automatic conv(input logic [9:0] c, input logic o, input logic u, input logic [6:0] n);
        ain_code <= c;
        ain_over <= o;
        ain_under <= u;
        n_samples <= n;
        trig(1'b1);
        for (int i = 0; i < 200 && !(sample_valid && sample_last); i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
    endtask : conv
    // Expected window match from the mode table with thresholds 0x100 and 0x300
    function automatic logic expw(input int m, input int v);
        case (m)
            1: return v < 'h100;
            2: return v > 'h300;
            3: return v > 'h100 && v < 'h300;
            4: return v < 'h100 || v > 'h300;
            default: return 1'b0;
        endcase
    endfunction : expw
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (codes[i]) rchk(8'h0a + 8'(i), 8'h00);
        rchk(8'h0d, 8'h00);
        rchk(8'h10, 8'h00);
        rchk(8'h11, 8'h00);
        wr(8'h3f, 8'hff);
        rchk(8'h3f, 8'h00);
        wr(8'h0d, 8'h5a);
        rchk(8'h0d, 8'h5a);
        wr(8'h0a, 8'hff);
        rchk(8'h0a, 8'h03);
        wr(8'h0a, 8'h00);
        conv(10'h155, 1'b0, 1'b0, 7'h01);
        `CHK(irq, 1'b0)
        rchk(8'h0b, 8'h01);
        wr(8'h0a, 8'h01);
        `CHK({result_ready_irq, irq}, 2'b11)
        wr(8'h0b, 8'h00);
        rchk(8'h0b, 8'h01);
        wr(8'h0b, 8'h01);
        `CHK(irq, 1'b0)
        rchk(8'h0b, 8'h00);
        wr(8'h0a, 8'h00);
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h01);
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h03);
        rchk(8'h13, 8'h01);
        rchk(8'h15, 8'h03);
        for (int m = 0; m < 6; m++) begin
            foreach (codes[k]) begin
                wr(8'h04, 8'(m));
                conv(codes[k], 1'b0, 1'b0, 7'h01);
                rchk(8'h0b, {6'h00, expw(m, int'(codes[k])), 1'b1});
                wr(8'h0b, 8'h03);
            end
        end
        wr(8'h04, 8'h04);
        wr(8'h0a, 8'h02);
        conv(10'h123, 1'b1, 1'b0, 7'h01);
        `CHK({window_match_irq, result_ready_irq, irq}, 3'b101)
        rchk(8'h10, 8'hff);
        rchk(8'h0b, 8'h00);
        rchk(8'h11, 8'h03);
        conv(10'h2aa, 1'b0, 1'b1, 7'h01);
        rchk(8'h10, 8'h00);
        rchk(8'h11, 8'h00);
        wr(8'h04, 8'h02);
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h80);
        conv(10'h3ff, 1'b1, 1'b0, 7'd64);
        rchk(8'h0b, 8'h03);
        rchk(8'h10, 8'hc0);
        rchk(8'h11, 8'hff);
        @(posedge clk) debug_halt <= 1'b1;
        #1 `CHK(conv_run, 1'b0)
        trig(1'b0);
        repeat (20) @(posedge clk);
        rchk(8'h0b, 8'h00);
        wr(8'h0c, 8'h01);
        rchk(8'h0c, 8'h01);
        `CHK(conv_run, 1'b1)
        conv(10'h077, 1'b0, 1'b0, 7'h02);
        rchk(8'h0b, 8'h01);
        rchk(8'h10, 8'hee);
        @(posedge clk) debug_halt <= 1'b0;
        tally_and_finish();
    end
endmodule : tb_top
